// *** acquisition_start_trigger_ctrl.sv ***
// Acquisition start trigger gate for frame-start triggers
`timescale 1ns/1ps
`default_nettype none
module acquisition_start_trigger_ctrl (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       trigger_enable_setting,
    input  wire logic       trigger_target_select,
    input  wire logic       trigger_origin_select,
    input  wire logic       edge_polarity_select,
    input  wire logic       host_trigger_command,
    input  wire logic       ext_burst_arm_signal,
    input  wire logic [7:0] frames_per_burst,
    input  wire logic       acquisition_active,
    input  wire logic       frame_trigger_in,
    output logic            frame_trigger_out,
    output logic            awaiting_arm,
    output logic            arm_pulse,
    output logic [7:0]      frames_taken,
    output logic            frames_setting_bad
);
    burst_trig_pkg::arm_state_t state_q;
    burst_trig_pkg::arm_state_t state_d;
    logic [7:0] count_q;
    logic [7:0] limit_q;
    logic       enable_q;
    logic       soft_arm;
    logic       line_arm;
    logic       arm_hit;
    logic       frame_ok;
    logic       last_frame;

    arm_edge_if edge_bus ();

    assign edge_bus.polarity = edge_polarity_select;

    arm_line_edge u_line_edge (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .line_in  (ext_burst_arm_signal),
        .edge_bus (edge_bus)
    );

    // Range check, true when value lies in 1..255
    function automatic logic in_range(input logic [7:0] v);
        in_range = (v >= burst_trig_pkg::FRAMES_MIN) && (v <= burst_trig_pkg::FRAMES_MAX);
    endfunction

    // Latch a legal burst length; out-of-range writes are refused
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            limit_q <= burst_trig_pkg::FRAMES_RESET;
        end else if (in_range(frames_per_burst)) begin
            limit_q <= frames_per_burst;
        end
    end

    assign frames_setting_bad = ~in_range(frames_per_burst);

    // Arm sources
    assign soft_arm = host_trigger_command
                    && trigger_target_select == burst_trig_pkg::SEL_ACQ_START
                    && trigger_origin_select == burst_trig_pkg::ORIGIN_SOFT;
    assign line_arm = edge_bus.edge_pulse
                    && trigger_origin_select == burst_trig_pkg::ORIGIN_LINE1;
    assign arm_hit  = acquisition_active && (soft_arm || line_arm);

    // Frame triggers pass only while acquisition is active, inside the window or at any time while gating is disabled
    assign frame_ok   = frame_trigger_in && acquisition_active
                      && (!trigger_enable_setting
                          || state_q == burst_trig_pkg::ST_AWAIT_FRAME);
    assign last_frame = (count_q + 8'h01) == limit_q;

    // Enable history, restart in the awaiting state on a fresh enable
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            enable_q <= 1'b0;
        end else begin
            enable_q <= trigger_enable_setting;
        end
    end

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            burst_trig_pkg::ST_AWAIT_ARM: begin
                if (arm_hit) begin
                    state_d = burst_trig_pkg::ST_AWAIT_FRAME;
                end
            end
            burst_trig_pkg::ST_AWAIT_FRAME: begin
                if (frame_ok && last_frame) begin
                    state_d = burst_trig_pkg::ST_AWAIT_ARM;
                end
            end
            default: state_d = burst_trig_pkg::ST_AWAIT_ARM;
        endcase
        if (!trigger_enable_setting || !enable_q) begin
            state_d = burst_trig_pkg::ST_AWAIT_ARM;
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= burst_trig_pkg::ST_AWAIT_ARM;
        end else begin
            state_q <= state_d;
        end
    end

    // Frame counter, cleared on each new window
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            count_q <= 8'h00;
        end else if (state_q != burst_trig_pkg::ST_AWAIT_FRAME) begin
            count_q <= 8'h00;
        end else if (frame_ok) begin
            count_q <= last_frame ? 8'h00 : count_q + 8'h01;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            frame_trigger_out <= 1'b0;
            arm_pulse         <= 1'b0;
            awaiting_arm      <= 1'b0;
            frames_taken      <= 8'h00;
        end else begin
            frame_trigger_out <= frame_ok;
            arm_pulse         <= trigger_enable_setting && enable_q
                                 && state_q == burst_trig_pkg::ST_AWAIT_ARM && arm_hit;
            awaiting_arm      <= trigger_enable_setting
                                 && state_d == burst_trig_pkg::ST_AWAIT_ARM;
            frames_taken      <= count_q;
        end
    end
endmodule // acquisition_start_trigger_ctrl
`default_nettype wire

// *** acquisition_start_trigger_ctrl_tb.sv ***
// Self-checking bench for the acquisition start trigger gate
`timescale 1ns/1ps
`default_nettype none
module acquisition_start_trigger_ctrl_tb;
    logic       clk_sys = 1'b0, srst = 1'b1, trigger_enable_setting = 1'b1, fire = 1'b0;
    logic       trigger_target_select = 1'b0, trigger_origin_select = 1'b0;
    logic       edge_polarity_select = 1'b0, host_trigger_command = 1'b0;
    logic       acquisition_active = 1'b0, frame_trigger_in = 1'b0;
    logic       ext_burst_arm_signal, frame_trigger_out, awaiting_arm, arm_pulse;
    logic       frames_setting_bad;
    logic [7:0] frames_per_burst = 8'h01, frames_taken;
    int         miscompares = 0, cmp_count = 0;
    always #4 clk_sys = ~clk_sys;
    acquisition_start_trigger_ctrl dut (.*);
    arm_line_src src (.clk_sys, .fire, .polarity(edge_polarity_select), .ext_burst_arm_signal);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Strobes rise two cycles apart, so no signal is set twice at one edge
    task automatic host_arm(input logic exp);
        @(negedge clk_sys);
        host_trigger_command = 1'b1;
        @(negedge clk_sys);
        host_trigger_command = 1'b0;
        chk(arm_pulse, exp);
    endtask
    task automatic frame(input logic exp);
        @(negedge clk_sys);
        frame_trigger_in = 1'b1;
        @(negedge clk_sys);
        frame_trigger_in = 1'b0;
        chk(frame_trigger_out, exp);
    endtask
    // One line edge must give exactly one arm pulse
    task automatic line_arm();
        logic [3:0] n;
        n = 4'h0;
        @(negedge clk_sys);
        fire = 1'b1;
        @(negedge clk_sys);
        fire = 1'b0;
        repeat (8) begin
            @(negedge clk_sys);
            n += arm_pulse;
        end
        chk(n == 1, 1'b1);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence; the bench plays the host
    // Host duty: capture mode stays continuous while gating is on
    initial begin
        repeat (5) @(negedge clk_sys);
        srst = 1'b0;
        acquisition_active = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(awaiting_arm, 1'b1);
        frame(1'b0);
        host_arm(1'b1);
        frame(1'b1);
        chk(awaiting_arm, 1'b1);
        frames_per_burst = 8'h03;
        @(negedge clk_sys);
        frames_per_burst = 8'h00;
        @(negedge clk_sys);
        chk(frames_setting_bad, 1'b1);
        host_arm(1'b1);
        host_arm(1'b0);
        repeat (2) frame(1'b1);
        chk(frames_taken, 8'h01);
        frame(1'b1);
        chk(frames_taken, 8'h02);
        frame(1'b0);
        frames_per_burst = 8'h01;
        trigger_target_select = burst_trig_pkg::SEL_FRAME;
        host_arm(1'b0);
        chk(frames_setting_bad, 1'b0);
        trigger_target_select = burst_trig_pkg::SEL_ACQ_START;
        trigger_origin_select = burst_trig_pkg::ORIGIN_LINE1;
        host_arm(1'b0);
        line_arm();
        frame(1'b1);
        edge_polarity_select = burst_trig_pkg::EDGE_FALLING;
        line_arm();
        frame(1'b1);
        trigger_enable_setting = 1'b0;
        frame(1'b1);
        chk(awaiting_arm, 1'b0);
        report_and_stop();
    end
    // Run needs about 60 cycles; this cuts a hang
    initial begin
        #20000;
        miscompares++;
        report_and_stop();
    end
endmodule // acquisition_start_trigger_ctrl_tb
`default_nettype wire

// *** arm_edge_if.sv ***
// Interface carrying the synchronised line edge between modules
`timescale 1ns/1ps
`default_nettype none
interface arm_edge_if;
    logic polarity;
    logic edge_pulse;
    modport detector (input polarity, output edge_pulse);
    modport consumer (output polarity, input edge_pulse);
endinterface
`default_nettype wire

// *** arm_line_edge.sv ***
// Line input synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module arm_line_edge (
    input  wire logic     clk_sys,
    input  wire logic     srst,
    input  wire logic     line_in,
    arm_edge_if.detector  edge_bus
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
        end
    end

    // Previous synchronised level for edge compare
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sync2_q;
        end
    end

    // One pulse per qualifying edge
    always_comb begin
        if (edge_bus.polarity == burst_trig_pkg::EDGE_FALLING) begin
            edge_bus.edge_pulse = prev_q & ~sync2_q;
        end else begin
            edge_bus.edge_pulse = sync2_q & ~prev_q;
        end
    end
endmodule // arm_line_edge
`default_nettype wire

// *** arm_line_src.sv ***
// Line one source model for the external arm signal
`timescale 1ns/1ps
`default_nettype none
module arm_line_src (
    input  wire logic clk_sys,
    input  wire logic fire,
    input  wire logic polarity,
    output var logic  ext_burst_arm_signal
);
    logic [2:0] hold_q = 3'h0;
    // Active level held five cycles so the synchroniser cannot miss it
    always @(posedge clk_sys)
        hold_q <= fire ? 3'h5 : hold_q - {2'h0, |hold_q};
    assign ext_burst_arm_signal = (|hold_q) ^ polarity;
endmodule // arm_line_src
`default_nettype wire

// *** burst_trig_chk.sv ***
// Port checks for the acquisition start trigger gate
`timescale 1ns/1ps
`default_nettype none
module burst_trig_chk (
    input wire logic       clk_sys,
    input wire logic       srst,
    input wire logic       trigger_enable_setting,
    input wire logic       trigger_target_select,
    input wire logic       trigger_origin_select,
    input wire logic       edge_polarity_select,
    input wire logic       host_trigger_command,
    input wire logic       ext_burst_arm_signal,
    input wire logic       acquisition_active,
    input wire logic       frame_trigger_in,
    input wire logic       frame_trigger_out,
    input wire logic       awaiting_arm,
    input wire logic       arm_pulse,
    input wire logic       frames_setting_bad,
    input wire logic [7:0] frames_per_burst
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Enable seen two cycles, so an arm may be taken
    sequence ready_s;
        awaiting_arm && acquisition_active && trigger_enable_setting
            && $past(trigger_enable_setting) && !$past(srst);
    endsequence
    sequence line_edge_s;
        $changed(ext_burst_arm_signal) && ext_burst_arm_signal != edge_polarity_select;
    endsequence
    a_frame_drop: assert property (
        trigger_enable_setting && awaiting_arm && frame_trigger_in |=> !frame_trigger_out)
        else $error("frame passed while waiting");
    a_free_pass: assert property (
        !trigger_enable_setting && acquisition_active && frame_trigger_in |=> frame_trigger_out)
        else $error("frame lost while disabled");
    a_out_cause: assert property (
        frame_trigger_out |-> $past(frame_trigger_in && acquisition_active))
        else $error("frame without cause");
    a_arm_leaves: assert property (arm_pulse |-> !awaiting_arm && $past(awaiting_arm))
        else $error("arm outside waiting");
    a_soft_arm: assert property (ready_s ##0 (host_trigger_command
        && !trigger_target_select && !trigger_origin_select) |=> arm_pulse)
        else $error("host arm missed");
    a_burst_close: assert property (frame_trigger_out && trigger_enable_setting
        && $past(trigger_enable_setting) && frames_per_burst == 8'h01
        && $stable(frames_per_burst) |-> awaiting_arm) else $error("window stays open");
    a_bad_flag: assert property (frames_setting_bad == (frames_per_burst == 8'h00))
        else $error("bad setting flag wrong");
    a_line_arm: assert property (
        ready_s ##0 line_edge_s ##0 trigger_origin_select |-> ##[3:5] arm_pulse)
        else $error("line arm missed");
endmodule // burst_trig_chk
bind acquisition_start_trigger_ctrl burst_trig_chk chk_i (.*);
`default_nettype wire

// *** burst_trig_pkg.sv ***
// Shared constants and types for the burst arming trigger control
package burst_trig_pkg;
    localparam int unsigned COUNT_W        = 8;
    localparam logic [7:0]  FRAMES_MIN     = 8'h01;
    localparam logic [7:0]  FRAMES_MAX     = 8'hff;
    localparam logic [7:0]  FRAMES_RESET   = 8'h01;
    localparam logic        SEL_ACQ_START  = 1'b0;
    localparam logic        SEL_FRAME      = 1'b1;
    localparam logic        ORIGIN_SOFT    = 1'b0;
    localparam logic        ORIGIN_LINE1   = 1'b1;
    localparam logic        EDGE_RISING    = 1'b0;
    localparam logic        EDGE_FALLING   = 1'b1;

    typedef enum logic [1:0] {
        ST_AWAIT_ARM,
        ST_AWAIT_FRAME
    } arm_state_t;
endpackage
